// ==== rtl/scil_pkg.sv ====
// Shared constants for the serial channel interrupt logic
package scil_pkg;

    // Register indices selected through the command register pointer
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_IMODE = 4'h1;
    localparam logic [3:0] REG_VECTOR = 4'h2;
    localparam logic [3:0] REG_EXTOPT = 4'h7;
    localparam logic [3:0] REG_MASTER = 4'h9;
    localparam logic [3:0] REG_EXTEN = 4'hF;
    localparam logic [3:0] RD_SPECIAL = 4'h1;
    localparam logic [3:0] RD_VECTOR = 4'h2;
    localparam logic [3:0] RD_PENDING = 4'h3;

    // Command field of the command register, bits 5..3
    localparam int CMD_LSB = 3;
    localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
    localparam logic [2:0] CMD_RESET_EXT = 3'h2;
    localparam logic [2:0] CMD_RESET_TX = 3'h5;
    localparam logic [2:0] CMD_ERR_RESET = 3'h6;
    localparam logic [2:0] CMD_RESET_IUS = 3'h7;

    // Interrupt mode register fields
    localparam int IM_EXT_IE = 0;
    localparam int IM_TX_IE = 1;
    localparam int IM_PAR_SPC = 2;
    localparam int IM_RX_LSB = 3;
    localparam logic [1:0] RXM_OFF = 2'h0;
    localparam logic [1:0] RXM_SPECIAL = 2'h3;

    // Master control register fields
    localparam int MC_VIS = 0;
    localparam int MC_NV = 1;
    localparam int MC_DLC = 2;
    localparam int MC_MIE = 3;
    localparam int MC_STAT_HI = 4;
    localparam int MC_SWACK = 5;
    localparam int MC_RST_LSB = 6;

    // Extended option and external enable register fields
    localparam int EO_RX_FOUR = 3;
    localparam int EO_TX_ENTRY = 5;
    localparam int EX_OPT_ACCESS = 0;

    // Pending status and special condition status bit positions
    localparam int PS_EXT = 3;
    localparam int SP_PARITY = 4;
    localparam int SP_EOF = 7;

    // Reset values
    localparam logic [7:0] RST_IMODE = 8'h00;
    localparam logic [7:0] RST_VECTOR = 8'h00;
    localparam logic [7:0] RST_EXTOPT = 8'h00;
    localparam logic [7:0] RST_MASTER = 8'h00;
    localparam logic [7:0] RST_EXTEN = 8'hF8;

    // Source index in the internal chain, and vector status codes
    localparam int SRC_EXT = 0;
    localparam int SRC_TX = 1;
    localparam int SRC_RX = 2;
    localparam logic [1:0] VS_TX = 2'h0;
    localparam logic [1:0] VS_EXT = 2'h1;
    localparam logic [1:0] VS_RX = 2'h2;
    localparam logic [1:0] VS_SPECIAL = 2'h3;

    // Receive thresholds in bytes
    localparam logic [3:0] RX_ONE_BYTE = 4'h1;
    localparam logic [3:0] RX_FOUR_BYTES = 4'h4;

    // Daisy chain settle time before the vector is taken
    localparam int CLK_NS = 10;
    localparam int SETTLE_NS = 200;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

endpackage

// ==== rtl/scil_sync.sv ====
// Two flip-flop synchroniser for the asynchronous chain pins
`timescale 1ns/1ps
module scil_sync
    import scil_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Pins and synchronised copies
    input wire logic [2:0] pin_i,
    output logic [2:0] sync_o
);

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] stable;
    } scil_sync_t;

    scil_sync_t s;
    scil_sync_t next_s;

    // First stage feeds only the second stage
    always_comb
    begin
        next_s = s;
        next_s.meta = pin_i;
        next_s.stable = s.meta;
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign sync_o = s.stable;

endmodule

// ==== rtl/scil_core.sv ====
// Interrupt logic of one serial channel: sources, chain, acknowledge
// Function
// - Receive ranks highest, transmit next, external/status lowest.
// - Receive character interrupt at one byte, or four bytes when threshold set.
// - The receive threshold also governs receive DMA requests.
// - Overrun, CRC/framing, end of frame are special; parity only if enabled.
// - Transmit pends on buffer empty, or entry empty when threshold set.
// - Transmit never pends before the first character was written.
// - External sources gated by own enables and master external enable.
// - No channel interrupt request while master interrupt enable is clear; receive DMA requests still go.
// - Processor interrupt ORs channel, external pin, timers and parallel port.
// - Transmit enable bit and two-bit receive mode field gate their sources.
// - Pending sets only when enabled; clears by command or servicing.
// - Pending status reads receive bit 5, transmit bit 4, external bit 3.
// - Under-service set on hardware acknowledge or software-acknowledge vector read.
// - A set under-service bit masks lower internal sources.
// - Acknowledge sets under-service only for the highest pending source.
// - Only reset-highest command or reset clears under-service bits.
// - Disable-lower-chain drives priority-out low.
// - Any set under-service bit forces priority-out low.
// - Outgoing request depends on pending bits and priority-in.
// - Request needs enable, pending, no higher service, priority-in, no acknowledge.
// - Priority-out follows priority-in, low during acknowledge when pending.
// - Vector driven on acknowledge unless no-vector; status merged if selected.
// - Status code 00 tx, 01 ext, 10 rx, 11 special, low or high.
`timescale 1ns/1ps
module scil_core
    import scil_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Processor register port
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    input wire logic cpu_data_sel_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic [7:0] rd_data_o,
    output logic rd_data_oe_o,
    // Channel datapath status
    input wire logic [3:0] rx_count_i,
    input wire logic [3:0] rx_special_i,
    input wire logic tx_buf_empty_i,
    input wire logic tx_entry_empty_i,
    input wire logic [5:0] ext_src_i,
    // Chain pins and other requesters
    input wire logic priority_in_i,
    input wire logic acknowledge_strobe_i,
    input wire logic external_irq_input_n_i,
    input wire logic counter_timer_req_i,
    input wire logic parallel_port_req_i,
    // Requests out
    output logic irq_o,
    output logic priority_out_o,
    output logic dma_rx_req_o
);

    typedef enum logic [1:0] {ACK_IDLE, ACK_SETTLE, ACK_DONE} scil_ack_t;

    typedef struct packed {
        logic [3:0] ptr;
        logic [7:0] imode;
        logic [7:0] vector;
        logic [7:0] extopt;
        logic [7:0] master;
        logic [7:0] exten;
        logic [7:0] special;
        logic [2:0] under_service;
        logic tx_pend;
        logic ext_pend;
        logic tx_written;
        logic tx_cond_q;
        logic [5:0] ext_q;
        scil_ack_t ast;
        logic [4:0] cnt;
        logic ack_req;
        logic irq;
        logic pri_out;
        logic dma_req;
        logic [7:0] rd_data;
        logic rd_oe;
    } scil_state_t;

    localparam logic [4:0] SETTLE_LAST = 5'(SETTLE_CYC - 1);

    // Highest set bit of a chain vector, one-hot
    function automatic logic [2:0] scil_highest(input logic [2:0] v);
        logic [2:0] r;
        r = 3'h0;
        if (v[SRC_RX])
            r[SRC_RX] = 1'b1;
        else if (v[SRC_TX])
            r[SRC_TX] = 1'b1;
        else if (v[SRC_EXT])
            r[SRC_EXT] = 1'b1;
        return r;
    endfunction

    // Vector with the source status code merged in low or high position
    function automatic logic [7:0] scil_vector(input logic [7:0] base,
        input logic [2:0] sel, input logic spc, input logic vector_includes_status,
        input logic hi);
        logic [7:0] v;
        logic [1:0] c;
        v = base;
        c = sel[SRC_RX] ? (spc ? VS_SPECIAL : VS_RX) :
            sel[SRC_TX] ? VS_TX : VS_EXT;
        if (vector_includes_status && (sel != 3'h0))
        begin
            if (hi)
            begin
                v[5] = c[1];
                v[6] = c[0];
            end
            else
            begin
                v[2] = c[1];
                v[1] = c[0];
            end
        end
        return v;
    endfunction

    scil_state_t s, next_s;
    logic [2:0] pin_sync, src_en, pend, allow, req_vec;
    logic pri_in_s, ack_s, ext_irq_s, rx_char, spc_any, int_req, cmd_ius, soft_rst, tx_cond;
    logic [1:0] rx_mode;
    logic [7:0] vec_now;
    logic [5:0] ext_chg;

    // Chain pins come from outside the clock domain
    scil_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .pin_i({priority_in_i, acknowledge_strobe_i, !external_irq_input_n_i}),
        .sync_o(pin_sync)
    );

    assign pri_in_s = pin_sync[2];
    assign ack_s = pin_sync[1];
    assign ext_irq_s = pin_sync[0]; // Inverted ahead of the flops so reset reads idle

    // Source conditions, enables and the internal chain
    always_comb
    begin
        rx_mode = s.imode[IM_RX_LSB +: 2];
        rx_char = rx_count_i >= (s.extopt[EO_RX_FOUR] ? RX_FOUR_BYTES
                                                      : RX_ONE_BYTE);
        spc_any = (|s.special[SP_EOF:SP_PARITY + 1])
                  | (s.imode[IM_PAR_SPC] & s.special[SP_PARITY]);
        src_en = {rx_mode != RXM_OFF, s.imode[IM_TX_IE],
                  s.imode[IM_EXT_IE]};
        pend[SRC_RX] = src_en[SRC_RX]
                       & (spc_any | (rx_char & (rx_mode != RXM_SPECIAL)));
        pend[SRC_TX] = s.tx_pend;
        pend[SRC_EXT] = s.ext_pend;
        // A source under service blocks itself and everything below it
        allow[SRC_RX] = !s.under_service[SRC_RX];
        allow[SRC_TX] = !(|s.under_service[SRC_RX:SRC_TX]);
        allow[SRC_EXT] = !(|s.under_service);
        req_vec = pend & src_en & allow;
        int_req = s.master[MC_MIE] & (|req_vec) & pri_in_s
                  & (s.ast == ACK_IDLE);
        vec_now = scil_vector(s.vector, scil_highest(req_vec), spc_any,
                              s.master[MC_VIS], s.master[MC_STAT_HI]);
        tx_cond = s.extopt[EO_TX_ENTRY] ? tx_entry_empty_i : tx_buf_empty_i;
        ext_chg = (ext_src_i ^ s.ext_q) & {s.exten[7:3], s.exten[1]};
    end

    // Register access, pending flags, acknowledge and outputs
    always_comb
    begin
        logic ctl_wr;
        logic tx_clr;
        logic ext_clr;
        logic err_clr;
        logic [2:0] ack_set;
        ctl_wr = cpu_wr_i && !cpu_data_sel_i;
        tx_clr = cpu_wr_i && cpu_data_sel_i;
        ext_clr = 1'b0;
        err_clr = 1'b0;
        cmd_ius = 1'b0;
        soft_rst = 1'b0;
        ack_set = 3'h0;
        next_s = s;
        next_s.tx_cond_q = tx_cond;
        next_s.ext_q = ext_src_i;
        next_s.tx_written = s.tx_written | tx_clr;

        // Writes through the pointer; a pointed access returns it to zero
        if (ctl_wr)
        begin
            if (s.ptr == REG_CMD)
            begin
                next_s.ptr = {cpu_wdata_i[CMD_LSB +: 3] == CMD_POINT_HIGH,
                              cpu_wdata_i[2:0]};
                case (cpu_wdata_i[CMD_LSB +: 3])
                    CMD_RESET_EXT: ext_clr = 1'b1;
                    CMD_RESET_TX: tx_clr = 1'b1;
                    CMD_ERR_RESET: err_clr = 1'b1;
                    CMD_RESET_IUS: cmd_ius = 1'b1;
                    default: ;
                endcase
            end
            else
            begin
                next_s.ptr = REG_CMD;
                case (s.ptr)
                    REG_IMODE: next_s.imode = cpu_wdata_i;
                    REG_VECTOR: next_s.vector = cpu_wdata_i;
                    REG_EXTOPT:
                        if (s.exten[EX_OPT_ACCESS])
                            next_s.extopt = cpu_wdata_i;
                    REG_MASTER:
                    begin
                        next_s.master = cpu_wdata_i;
                        soft_rst = |cpu_wdata_i[MC_RST_LSB +: 2];
                    end
                    REG_EXTEN: next_s.exten = cpu_wdata_i;
                    default: ;
                endcase
            end
        end

        // Reads; the vector read doubles as the software acknowledge
        if (cpu_rd_i && !cpu_data_sel_i)
        begin
            next_s.ptr = REG_CMD;
            case (s.ptr)
                RD_SPECIAL: next_s.rd_data = s.special;
                RD_VECTOR:
                begin
                    next_s.rd_data = vec_now;
                    if (s.master[MC_SWACK] && int_req)
                        ack_set = scil_highest(req_vec);
                end
                RD_PENDING: next_s.rd_data = {2'h0, pend & src_en,
                                              3'h0};
                default: next_s.rd_data = 8'h00;
            endcase
        end

        // Hardware acknowledge: wait for the chain to settle, then claim
        case (s.ast)
            ACK_IDLE:
                if (ack_s)
                begin
                    next_s.ast = ACK_SETTLE;
                    next_s.cnt = 5'h00;
                    next_s.ack_req = int_req;
                end
            ACK_SETTLE:
                if (!ack_s)
                    next_s.ast = ACK_IDLE;
                else if (s.cnt == SETTLE_LAST)
                begin
                    next_s.ast = ACK_DONE;
                    if (s.ack_req && pri_in_s)
                    begin
                        ack_set = scil_highest(req_vec);
                        next_s.rd_data = vec_now;
                        next_s.rd_oe = !s.master[MC_NV];
                    end
                end
                else
                    next_s.cnt = s.cnt + 5'h01;
            ACK_DONE:
                if (!ack_s)
                begin
                    next_s.ast = ACK_IDLE;
                    next_s.rd_oe = 1'b0;
                end
            default: next_s.ast = ACK_IDLE;
        endcase

        // Under-service: the reset-highest command clears one bit; soft reset below clears all
        next_s.under_service = (s.under_service & ~(cmd_ius ? scil_highest(s.under_service) : 3'h0))
                     | ack_set;
        // Sticky flags; a new event wins over a clear in the same cycle
        next_s.special[SP_EOF:SP_PARITY] = (err_clr ? 4'h0
            : s.special[SP_EOF:SP_PARITY]) | rx_special_i;
        next_s.tx_pend = (s.tx_pend & !tx_clr)
            | (tx_cond & !s.tx_cond_q & s.tx_written
               & s.imode[IM_TX_IE]);
        next_s.ext_pend = (s.ext_pend & !ext_clr)
            | ((|ext_chg) & s.imode[IM_EXT_IE]);
        // Software reset of the channel's interrupt state
        if (soft_rst)
        begin
            next_s.master = RST_MASTER;
            next_s.under_service = 3'h0;
            next_s.tx_pend = 1'b0;
            next_s.ext_pend = 1'b0;
            next_s.tx_written = 1'b0;
            next_s.special = 8'h00;
        end
        // Registered outputs
        next_s.irq = int_req | ext_irq_s | counter_timer_req_i
                     | parallel_port_req_i;
        next_s.pri_out = pri_in_s && !s.master[MC_DLC] && !(|s.under_service)
            && !((s.ast != ACK_IDLE) && (|(pend & src_en)));
        next_s.dma_req = rx_char;
    end

    // State register; reset leaves the chain open
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s <= '0;
            s.imode <= RST_IMODE;
            s.vector <= RST_VECTOR;
            s.extopt <= RST_EXTOPT;
            s.master <= RST_MASTER;
            s.exten <= RST_EXTEN;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign irq_o = s.irq;
    assign priority_out_o = s.pri_out;
    assign dma_rx_req_o = s.dma_req;
    assign rd_data_o = s.rd_data;
    assign rd_data_oe_o = s.rd_oe;

    // Checks on the chain, flags and outputs
    mie_gate_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !s.master[MC_MIE] && !ext_irq_s && !counter_timer_req_i
        && !parallel_port_req_i |=> !irq_o)
        else $error("request raised while master enable clear");
    rank_order_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        $rose(s.under_service[SRC_TX]) |-> !$past(req_vec[SRC_RX]))
        else $error("transmit served ahead of receive");
    dlc_low_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        s.master[MC_DLC] |=> !priority_out_o)
        else $error("priority out high with lower chain disabled");
    ius_low_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (|s.under_service) |=> !priority_out_o)
        else $error("priority out high while under service");
    chain_follow_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        s.ast == ACK_IDLE && !s.master[MC_DLC] && s.under_service == 3'h0
        |=> priority_out_o == $past(pri_in_s))
        else $error("priority out does not follow priority in");
    tx_first_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !s.tx_written |=> !s.tx_pend)
        else $error("transmit pending before first character");
    ius_clear_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (|($past(s.under_service) & ~s.under_service)) |-> $past(cmd_ius || soft_rst))
        else $error("under service cleared without command");
    nv_vector_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        $rose(rd_data_oe_o) |-> !$past(s.master[MC_NV])
        && rd_data_o == $past(vec_now))
        else $error("vector driven wrongly on acknowledge");
    rx_four_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        s.extopt[EO_RX_FOUR] && rx_count_i < RX_FOUR_BYTES |=> !dma_rx_req_o)
        else $error("receive request below four bytes");
    ext_set_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (|ext_chg) && s.imode[IM_EXT_IE] && !soft_rst |=> s.ext_pend)
        else $error("external change not latched");

endmodule

// ==== test/scil_cpu_model.sv ====
// Processor model: register accesses and interrupt acknowledge cycles
`timescale 1ns/1ps
module scil_cpu_model
    import scil_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Register strobes and data
    output logic cpu_wr_o,
    output logic cpu_rd_o,
    output logic cpu_data_sel_o,
    output logic [7:0] cpu_wdata_o,
    // Acknowledge pin
    output logic ack_o
);
    // Idle bus from time zero
    initial
    begin
        cpu_wr_o = 1'b0;
        cpu_rd_o = 1'b0;
        cpu_data_sel_o = 1'b0;
        cpu_wdata_o = 8'h00;
        ack_o = 1'b0;
    end

    // One strobe for one edge; released data is inverted so a stale byte never passes
    task automatic strobe(input logic rd, input logic sel, input logic [7:0] d);
    begin
        @(posedge ref_clk_i);
        cpu_wr_o <= !rd;
        cpu_rd_o <= rd;
        cpu_data_sel_o <= sel;
        cpu_wdata_o <= d;
        @(posedge ref_clk_i);
        cpu_wr_o <= 1'b0;
        cpu_rd_o <= 1'b0;
        cpu_wdata_o <= ~d;
    end
    endtask

    // Pointer write; the upper bank needs the point-high code
    task automatic point(input logic [3:0] idx);
    begin
        strobe(1'b0, 1'b0, {2'h0, idx[3] ? CMD_POINT_HIGH : 3'h0, idx[2:0]});
    end
    endtask

    // Pointer and access always go as one pair
    task automatic wr_reg(input logic [3:0] idx, input logic [7:0] d);
    begin
        point(idx);
        strobe(1'b0, 1'b0, d);
    end
    endtask

    task automatic rd_reg(input logic [3:0] idx);
    begin
        point(idx);
        strobe(1'b1, 1'b0, 8'h00);
    end
    endtask

    // Commands other than point-high leave the pointer at zero; reset-highest closes each service
    task automatic command(input logic [2:0] c);
    begin
        strobe(1'b0, 1'b0, {2'h0, c, 3'h0});
    end
    endtask

    // Acknowledge level, held until the caller drops it
    task automatic ack(input logic on);
    begin
        @(posedge ref_clk_i);
        ack_o <= on;
    end
    endtask
endmodule

// ==== test/scil_core_tb.sv ====
// Self-checking bench for the serial channel interrupt logic
`timescale 1ns/1ps
module scil_core_tb
    import scil_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wr, rd, sel, ack_pin, rd_oe, irq, pout, dma;
    logic [7:0] wdata, rd_data, v;
    logic [3:0] rx_count = 4'h0;
    logic [3:0] rx_special = 4'h0;
    logic [5:0] ext_src = 6'h00;
    logic tx_be = 1'b0;
    logic pin_in = 1'b1;
    logic counter_timer = 1'b0, ppr = 1'b0, tx_entry = 1'b0, ext_n = 1'b1;
    logic [31:0] seed = 32'h16;
    int fails = 0;
    int cmp_count = 0;
    int rx_p = 0;
    int tx_p = 0;
    int ext_p = 0;

    // Free-running clock
    always #5 ref_clk_i = ~ref_clk_i;

    scil_cpu_model i_scil_cpu_model (.ref_clk_i(ref_clk_i), .cpu_wr_o(wr), .cpu_rd_o(rd),
        .cpu_data_sel_o(sel), .cpu_wdata_o(wdata), .ack_o(ack_pin));

    scil_core i_scil_core (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cpu_wr_i(wr),
        .cpu_rd_i(rd), .cpu_data_sel_i(sel), .cpu_wdata_i(wdata), .rd_data_o(rd_data),
        .rd_data_oe_o(rd_oe), .rx_count_i(rx_count), .rx_special_i(rx_special),
        .tx_buf_empty_i(tx_be), .tx_entry_empty_i(tx_entry), .ext_src_i(ext_src),
        .priority_in_i(pin_in), .acknowledge_strobe_i(ack_pin),
        .external_irq_input_n_i(ext_n), .counter_timer_req_i(counter_timer),
        .parallel_port_req_i(ppr), .irq_o(irq), .priority_out_o(pout),
        .dma_rx_req_o(dma));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Expected pending status byte from the bench's own flags
    function automatic logic [7:0] pend();
        return {2'h0, rx_p[0], tx_p[0], ext_p[0], 3'h0};
    endfunction

    // Expected vector: status code low in bits 2..1, high in bits 5 and 6
    function automatic logic [7:0] vec(input logic [1:0] c, input logic hi);
        return hi ? {v[7], c[0], c[1], v[4:0]} : {v[7:3], c, v[0]};
    endfunction

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    begin
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
    begin
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    end
    endtask

    task automatic step(input int n);
    begin
        repeat (n) @(posedge ref_clk_i);
        #1;
    end
    endtask

    // Read data lands one edge after the strobe edge
    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] e, input string n);
    begin
        i_scil_cpu_model.rd_reg(idx);
        step(1);
        chk8(n, e, rd_data);
    end
    endtask

    task automatic end_of_test();
    begin
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        fails++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        step(4);
        chk1("prio_out", 1'b1, pout);
        rd_chk(RD_PENDING, 8'h00, "pending");
        seed = xorshift(seed);
        v = seed[7:0];
        i_scil_cpu_model.wr_reg(REG_VECTOR, v);
        i_scil_cpu_model.wr_reg(REG_IMODE, 8'h02);
        @(posedge ref_clk_i);
        tx_be <= 1'b1;
        rd_chk(RD_PENDING, 8'h00, "pending");
        // Master enable goes on once the transmit source is set up, before the others
        i_scil_cpu_model.wr_reg(REG_MASTER, 8'h08);
        i_scil_cpu_model.strobe(1'b0, 1'b1, seed[15:8]);
        tx_be <= 1'b0;
        @(posedge ref_clk_i);
        tx_be <= 1'b1;
        tx_p = 1;
        step(3);
        chk1("irq", 1'b1, irq);
        rd_chk(RD_PENDING, pend(), "pending");
        i_scil_cpu_model.wr_reg(REG_IMODE, 8'h0A);
        @(posedge ref_clk_i);
        rx_count <= RX_ONE_BYTE;
        rx_p = 1;
        step(3);
        chk1("dma", 1'b1, dma);
        rd_chk(RD_PENDING, pend(), "pending");
        i_scil_cpu_model.wr_reg(REG_EXTEN, 8'hF9);
        i_scil_cpu_model.wr_reg(REG_EXTOPT, 8'h08);
        rx_p = 0;
        step(2);
        chk1("dma", 1'b0, dma);
        rd_chk(RD_PENDING, pend(), "pending");
        @(posedge ref_clk_i);
        rx_count <= RX_FOUR_BYTES;
        rx_p = 1;
        // Parity is logged in the status but is no special condition here
        @(posedge ref_clk_i);
        rx_special <= 4'h1;
        @(posedge ref_clk_i);
        rx_special <= 4'h2;
        @(posedge ref_clk_i);
        rx_special <= 4'h0;
        rd_chk(RD_SPECIAL, 8'h30, "special");
        i_scil_cpu_model.command(CMD_ERR_RESET);
        rd_chk(RD_SPECIAL, 8'h00, "special");
        i_scil_cpu_model.wr_reg(REG_IMODE, 8'h0B);
        @(posedge ref_clk_i);
        ext_src <= 6'h01;
        rd_chk(RD_PENDING, pend(), "pending");
        @(posedge ref_clk_i);
        ext_src <= 6'h09;
        ext_p = 1;
        rd_chk(RD_PENDING, pend(), "pending");
        i_scil_cpu_model.command(CMD_RESET_EXT);
        ext_p = 0;
        rd_chk(RD_PENDING, pend(), "pending");
        // Hardware acknowledge with status in the low bits
        i_scil_cpu_model.wr_reg(REG_MASTER, 8'h09);
        i_scil_cpu_model.ack(1'b1);
        step(28);
        chk1("vec_oe", 1'b1, rd_oe);
        chk8("vector", vec(VS_RX, 1'b0), rd_data);
        chk1("prio_out", 1'b0, pout);
        i_scil_cpu_model.ack(1'b0);
        step(6);
        chk1("vec_oe", 1'b0, rd_oe);
        chk1("irq", 1'b0, irq);
        i_scil_cpu_model.command(CMD_RESET_IUS);
        step(3);
        chk1("irq", 1'b1, irq);
        chk1("prio_out", 1'b1, pout);
        @(posedge ref_clk_i);
        pin_in <= 1'b0;
        step(5);
        chk1("irq", 1'b0, irq);
        chk1("prio_out", 1'b0, pout);
        @(posedge ref_clk_i);
        pin_in <= 1'b1;
        step(5);
        // Software acknowledge, status high; receive outranks transmit
        i_scil_cpu_model.wr_reg(REG_MASTER, 8'h39);
        rd_chk(RD_VECTOR, vec(VS_RX, 1'b1), "sw_vector");
        step(2);
        chk1("irq", 1'b0, irq);
        i_scil_cpu_model.command(CMD_RESET_IUS);
        @(posedge ref_clk_i);
        rx_count <= 4'h0;
        rx_p = 0;
        step(3);
        rd_chk(RD_VECTOR, vec(VS_TX, 1'b1), "sw_vector");
        i_scil_cpu_model.command(CMD_RESET_IUS);
        i_scil_cpu_model.wr_reg(REG_MASTER, 8'h0C);
        step(3);
        chk1("prio_out", 1'b0, pout);
        i_scil_cpu_model.wr_reg(REG_MASTER, 8'h00);
        step(3);
        chk1("irq", 1'b0, irq);
        // Transmit threshold on the entry location, then a soft reset
        i_scil_cpu_model.command(CMD_RESET_TX);
        tx_p = 0;
        i_scil_cpu_model.wr_reg(REG_EXTOPT, 8'h20);
        rd_chk(RD_PENDING, pend(), "pending");
        @(posedge ref_clk_i);
        tx_entry <= 1'b1;
        tx_p = 1;
        step(2);
        rd_chk(RD_PENDING, pend(), "pending");
        i_scil_cpu_model.wr_reg(REG_MASTER, 8'h40);
        tx_p = 0;
        rd_chk(RD_PENDING, pend(), "pending");
        chk1("prio_out", 1'b1, pout);
        // Special-condition-only receive mode reports the special code
        i_scil_cpu_model.wr_reg(REG_IMODE, 8'h18);
        i_scil_cpu_model.wr_reg(REG_MASTER, 8'h39);
        @(posedge ref_clk_i);
        rx_special <= 4'h2;
        @(posedge ref_clk_i);
        rx_special <= 4'h0;
        rd_chk(RD_VECTOR, vec(VS_SPECIAL, 1'b1), "sw_vector");
        i_scil_cpu_model.command(CMD_ERR_RESET);
        i_scil_cpu_model.command(CMD_RESET_IUS);
        @(posedge ref_clk_i);
        counter_timer <= 1'b1;
        step(3);
        chk1("irq", 1'b1, irq);
        // External pin and parallel port reach the processor request too
        counter_timer <= 1'b0;
        ext_n <= 1'b0;
        step(5);
        chk1("irq", 1'b1, irq);
        ext_n <= 1'b1;
        ppr <= 1'b1;
        step(5);
        chk1("irq", 1'b1, irq);
        ppr <= 1'b0;
        step(3);
        chk1("irq", 1'b0, irq);
        end_of_test();
    end
endmodule
